// file: common/tile_status_pkg.sv
// Shared constants, field positions and carrier types for the tile status bank
package tile_status_pkg;

  // Register index width and data width of the status port
  localparam int PS_ADDR_W = 8;
  localparam int PS_DATA_W = 32;

  // Register numbers on the processor-status port
  localparam logic [7:0] OFS_TILE_BOOT_STATUS      = 8'h03;
  localparam logic [7:0] OFS_SECURITY_CONFIG       = 8'h05;
  localparam logic [7:0] OFS_RING_OSC_CONTROL      = 8'h06;
  localparam logic [7:0] OFS_TILE_CELL_OSC_COUNT   = 8'h07;
  localparam logic [7:0] OFS_TILE_WIRE_OSC_COUNT   = 8'h08;
  localparam logic [7:0] OFS_PERIPH_CELL_OSC_COUNT = 8'h09;
  localparam logic [7:0] OFS_PERIPH_WIRE_OSC_COUNT = 8'h0A;
  localparam logic [7:0] OFS_RAM_SIZE_BYTES        = 8'h0C;
  localparam logic [7:0] OFS_DEBUG_STATUS_SNAPSHOT = 8'h10;
  localparam logic [7:0] OFS_DEBUG_PC_SNAPSHOT     = 8'h11;

  // Boot status field positions
  localparam int BOOT_PROC_NUM_LSB   = 16;
  localparam int BOOT_OVERRIDE_BIT   = 8;
  localparam int BOOT_CORE1_OFF_BIT  = 5;
  localparam int BOOT_OTP_NOPOLL_BIT = 4;
  localparam int BOOT_FROM_RAM_BIT   = 3;
  localparam int BOOT_FROM_JTAG_BIT  = 2;
  localparam int BOOT_PLL_MODE_LSB   = 0;

  // Security configuration field positions
  localparam int SEC_WRITE_LOCK_BIT   = 31;
  localparam int SEC_GLOBAL_DBG_BIT   = 14;
  localparam int SEC_OTP_LOCK_ALL_BIT = 12;
  localparam int SEC_OTP_SECTOR_LSB   = 8;
  localparam int SEC_OTP_REDUND_BIT   = 7;
  localparam int SEC_BOOT_OTP_BIT     = 5;
  localparam int SEC_JTAG_CFG_BIT     = 4;
  localparam int SEC_JTAG_TAP_BIT     = 0;
  localparam logic [31:0] SEC_WMASK   = 32'h80005FB1;
  localparam logic [31:0] SEC_RESET   = 32'h00000000;

  // Ring oscillator control fields and reset
  localparam int OSC_CORE_EN_BIT      = 1;
  localparam int OSC_PERIPH_EN_BIT    = 0;
  localparam logic [1:0] OSC_CTRL_RESET = 2'h0;
  localparam int OSC_COUNT_W          = 16;

  // Debug status snapshot: writable mask and read-only issue-mode bit
  localparam logic [10:0] DBG_STATUS_WMASK = 11'h6DF;
  localparam int DBG_ISSUE_MODE_BIT        = 8;
  localparam logic [10:0] DBG_STATUS_RESET = 11'h000;
  localparam logic [31:0] DBG_PC_RESET     = 32'h00000000;

  // Input synchroniser depth for pins
  localparam int SYNC_STAGES = 3;

  // Processor-status request from the core
  typedef struct packed {
    logic                 rd;
    logic                 wr;
    logic [PS_ADDR_W-1:0] addr;
    logic [PS_DATA_W-1:0] wdata;
  } ps_req_s;

  // Boot straps and boot state presented by the tile
  typedef struct packed {
    logic [7:0] proc_number;
    logic       boot_mode_override;
    logic       core1_off;
    logic       otp_no_poll;
    logic       boot_from_ram;
    logic       boot_from_jtag;
    logic [1:0] pll_mode;
  } boot_straps_s;

  // Decoded security controls sent to the rest of the tile
  typedef struct packed {
    logic       write_locked;
    logic       global_debug_disable;
    logic       otp_lock_all;
    logic [3:0] otp_sector_lock;
    logic       otp_redundancy_en;
    logic       boot_from_otp;
    logic       jtag_cfg_deny;
    logic       jtag_tap_disable;
  } sec_ctrl_s;

endpackage

// file: hw/osc_edge_counter.sv
// Counts edges of one asynchronous ring oscillator in the core clock domain
`timescale 1ns/1ns
module osc_edge_counter #(
  parameter int COUNT_W = 16
) (
  // Clock and power-on clear (not the system reset)
  input  wire logic               ref_clk,
  input  wire logic               por_rst,
  // Raw oscillator output, asynchronous
  input  wire logic               osc_in,
  // Count in core domain
  output logic [COUNT_W-1:0]      count
);

  logic osc_s1_reg;
  logic osc_s2_reg;
  logic osc_s3_reg;
  logic level_reg;

  // Three-stage synchroniser, first stage read only by the second
  always_ff @(posedge ref_clk) begin
    osc_s1_reg <= osc_in;
    osc_s2_reg <= osc_s1_reg;
    osc_s3_reg <= osc_s2_reg;
  end

  // Settled level follows once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (por_rst) begin
      level_reg <= 1'b0;
    end else if (osc_s2_reg == osc_s3_reg) begin
      level_reg <= osc_s3_reg;
    end
  end

  // Count rising edges; sys_rst never reaches this counter
  always_ff @(posedge ref_clk) begin
    if (por_rst) begin
      count <= '0;
    end else if ((osc_s2_reg == osc_s3_reg) && osc_s3_reg && !level_reg) begin
      count <= count + COUNT_W'(1);
    end
  end

endmodule

// file: hw/tile_status_security_regs.sv
// Processor-status register bank: boot status, security, ring oscillators, debug snapshot
//
// Summary of operation
// - Boot status bits 23:16 report this tile's processor number.
// - Boot status bit 3 boot from RAM, bit 2 from JTAG, 1:0 PLL mode.
// - Boot status bit 5 core1 off, bit 4 no OTP polling, bit 8 override.
// - Security bit 31 set blocks any further software write to security register.
// - Security bit 14 disables global debug, bit 0 disables JTAG debug TAP.
// - Security bit 4 denies JTAG config access; bit 5 forces boot from OTP.
// - Security bits 11:8 lock sectors, 12 locks all, 7 enables redundancy.
// - Security register is loaded from the OTP security word masked by SEC_WMASK.
// - Four ring oscillators; control bit 1 core, bit 0 peripheral, reset 0.
// - Four read-only registers show 16-bit counts in bits 15:0.
// - Oscillator counts survive system reset.
// - Oscillators run asynchronous to the core clock, usable as entropy.
// - RAM size register shows byte size in 31:2, bits 1:0 zero.
// - Debug entry captures status word: bit 10 ASID, 7 fast, 6 paused.
// - Captured status bit 4 kernel, bit 3 interrupt handler, bit 2 enabling.
// - Captured status bit 1 interrupts enabled, bit 0 events enabled.
// - Captured bit 9 kernel-entry issue mode; bit 8 read-only current mode.
// - Debug entry captures full 32-bit saved program counter.
// - Core reaches registers by status reads and writes; bank serves them.
`timescale 1ns/1ns
module tile_status_security_regs #(
  parameter logic [31:0] RAM_SIZE = 32'h00010000
) (
  // Clock and resets
  input  wire logic                              ref_clk,
  input  wire logic                              sys_rst,
  input  wire logic                              por_rst,
  // Processor-status port
  input  wire tile_status_pkg::ps_req_s          ps_req,
  output logic [tile_status_pkg::PS_DATA_W-1:0]  ps_rdata,
  output logic                                   ps_rvalid,
  output logic                                   ps_wack,
  output logic                                   ps_werr,
  // Boot straps from pins
  input  wire tile_status_pkg::boot_straps_s     boot_straps,
  // OTP security word load
  input  wire logic                              otp_load,
  input  wire logic [31:0]                       otp_security_word,
  // Debug entry capture
  input  wire logic                              debug_mode,
  input  wire logic                              debug_enter,
  input  wire logic [10:0]                       saved_status_word,
  input  wire logic [31:0]                       saved_program_counter,
  // Ring oscillators
  input  wire logic [3:0]                        osc_raw,
  output logic                                   core_osc_en,
  output logic                                   periph_osc_en,
  // Security controls to the tile
  output tile_status_pkg::sec_ctrl_s             sec_ctrl
);
  import tile_status_pkg::*;

  localparam int STRAP_W = $bits(boot_straps_s);

  // Strap synchroniser stages
  logic [STRAP_W-1:0] strap_s1_reg;
  logic [STRAP_W-1:0] strap_s2_reg;
  logic [STRAP_W-1:0] strap_s3_reg;
  logic [STRAP_W-1:0] strap_reg;
  logic [STRAP_W-1:0] strap_next;
  boot_straps_s       straps;

  // Register state
  logic [31:0]        security_reg;
  logic [1:0]         osc_ctrl_reg;
  logic [10:0]        dbg_status_reg;
  logic [31:0]        dbg_pc_reg;

  // Oscillator counts
  logic [OSC_COUNT_W-1:0] osc_count [4];

  // Decode
  logic               wr_hit_sec;
  logic               wr_hit_osc;
  logic               wr_hit_dstat;
  logic               wr_hit_dpc;
  logic               wr_ok;
  logic [31:0]        rdata_next;
  logic [31:0]        boot_word;

  // Three-flop sync of boot straps
  always_ff @(posedge ref_clk) begin
    strap_s1_reg <= boot_straps;
    strap_s2_reg <= strap_s1_reg;
    strap_s3_reg <= strap_s2_reg;
  end

  // Bits change only where stages two and three agree
  assign strap_next = (strap_s3_reg & ~(strap_s2_reg ^ strap_s3_reg))
                    | (strap_reg & (strap_s2_reg ^ strap_s3_reg));

  // Settled strap values
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      strap_reg <= '0;
    end else begin
      strap_reg <= strap_next;
    end
  end

  assign straps = boot_straps_s'(strap_reg);

  // Boot status word assembly, reserved bits zero
  always_comb begin
    boot_word = 32'h00000000;
    boot_word[BOOT_PROC_NUM_LSB +: 8] = straps.proc_number;
    boot_word[BOOT_FROM_RAM_BIT]      = straps.boot_from_ram;
    boot_word[BOOT_FROM_JTAG_BIT]     = straps.boot_from_jtag;
    boot_word[BOOT_PLL_MODE_LSB +: 2] = straps.pll_mode;
    boot_word[BOOT_CORE1_OFF_BIT]     = straps.core1_off;
    boot_word[BOOT_OTP_NOPOLL_BIT]    = straps.otp_no_poll;
    boot_word[BOOT_OVERRIDE_BIT]      = straps.boot_mode_override;
  end

  // Write decode with refusal conditions
  assign wr_hit_sec   = ps_req.wr && (ps_req.addr == OFS_SECURITY_CONFIG);
  assign wr_hit_osc   = ps_req.wr && (ps_req.addr == OFS_RING_OSC_CONTROL);
  assign wr_hit_dstat = ps_req.wr && (ps_req.addr == OFS_DEBUG_STATUS_SNAPSHOT);
  assign wr_hit_dpc   = ps_req.wr && (ps_req.addr == OFS_DEBUG_PC_SNAPSHOT);
  assign wr_ok = (wr_hit_sec && !security_reg[SEC_WRITE_LOCK_BIT])
               || wr_hit_osc
               || ((wr_hit_dstat || wr_hit_dpc) && debug_mode);

  // Security register: OTP copy masked by SEC_WMASK, software write unless locked
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      security_reg <= SEC_RESET;
    end else if (otp_load) begin
      security_reg <= otp_security_word & SEC_WMASK;
    end else if (wr_hit_sec && !security_reg[SEC_WRITE_LOCK_BIT]) begin
      security_reg <= ps_req.wdata & SEC_WMASK;
    end
  end

  // Security controls decoded into the tile
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sec_ctrl <= '0;
    end else begin
      sec_ctrl.write_locked         <= security_reg[SEC_WRITE_LOCK_BIT];
      sec_ctrl.global_debug_disable <= security_reg[SEC_GLOBAL_DBG_BIT];
      sec_ctrl.jtag_tap_disable     <= security_reg[SEC_JTAG_TAP_BIT];
      sec_ctrl.jtag_cfg_deny        <= security_reg[SEC_JTAG_CFG_BIT];
      sec_ctrl.boot_from_otp        <= security_reg[SEC_BOOT_OTP_BIT];
      sec_ctrl.otp_sector_lock      <= security_reg[SEC_OTP_SECTOR_LSB +: 4];
      sec_ctrl.otp_lock_all         <= security_reg[SEC_OTP_LOCK_ALL_BIT];
      sec_ctrl.otp_redundancy_en    <= security_reg[SEC_OTP_REDUND_BIT];
    end
  end

  // Ring oscillator control, cleared at reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      osc_ctrl_reg <= OSC_CTRL_RESET;
    end else if (wr_hit_osc) begin
      osc_ctrl_reg <= ps_req.wdata[1:0];
    end
  end

  // Oscillator enables to the ring macros
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      core_osc_en   <= 1'b0;
      periph_osc_en <= 1'b0;
    end else begin
      core_osc_en   <= osc_ctrl_reg[OSC_CORE_EN_BIT];
      periph_osc_en <= osc_ctrl_reg[OSC_PERIPH_EN_BIT];
    end
  end

  // One synchronised edge counter per oscillator
  generate
    for (genvar i = 0; i < 4; i++) begin : g_osc
      osc_edge_counter #(
        .COUNT_W (OSC_COUNT_W)
      ) u_cnt (
        .ref_clk (ref_clk),
        .por_rst (por_rst),
        .osc_in  (osc_raw[i]),
        .count   (osc_count[i])
      );
    end
  endgenerate

  // Debug status snapshot: capture on entry, debug writes to writable bits
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dbg_status_reg <= DBG_STATUS_RESET;
    end else if (debug_enter) begin
      // Reserved bit 5 is dropped on capture so it reads zero
      dbg_status_reg <= saved_status_word
                      & (DBG_STATUS_WMASK | (11'h001 << DBG_ISSUE_MODE_BIT));
    end else if (wr_hit_dstat && debug_mode) begin
      dbg_status_reg <= (ps_req.wdata[10:0] & DBG_STATUS_WMASK)
                      | (dbg_status_reg & ~DBG_STATUS_WMASK);
    end
  end

  // Debug program counter snapshot
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dbg_pc_reg <= DBG_PC_RESET;
    end else if (debug_enter) begin
      dbg_pc_reg <= saved_program_counter;
    end else if (wr_hit_dpc && debug_mode) begin
      dbg_pc_reg <= ps_req.wdata;
    end
  end

  // Read mux, unmapped and reserved bits read zero
  always_comb begin
    rdata_next = 32'h00000000;
    case (ps_req.addr)
      OFS_TILE_BOOT_STATUS:      rdata_next = boot_word;
      OFS_SECURITY_CONFIG:       rdata_next = security_reg;
      OFS_RING_OSC_CONTROL:      rdata_next = {30'h00000000, osc_ctrl_reg};
      OFS_TILE_CELL_OSC_COUNT:   rdata_next = {16'h0000, osc_count[0]};
      OFS_TILE_WIRE_OSC_COUNT:   rdata_next = {16'h0000, osc_count[1]};
      OFS_PERIPH_CELL_OSC_COUNT: rdata_next = {16'h0000, osc_count[2]};
      OFS_PERIPH_WIRE_OSC_COUNT: rdata_next = {16'h0000, osc_count[3]};
      OFS_RAM_SIZE_BYTES:        rdata_next = {RAM_SIZE[31:2], 2'h0};
      OFS_DEBUG_STATUS_SNAPSHOT: rdata_next = {21'h000000, dbg_status_reg};
      OFS_DEBUG_PC_SNAPSHOT:     rdata_next = dbg_pc_reg;
      default:                   rdata_next = 32'h00000000;
    endcase
  end

  // Registered read answer, one cycle after the request
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ps_rdata  <= 32'h00000000;
      ps_rvalid <= 1'b0;
    end else begin
      ps_rvalid <= ps_req.rd;
      if (ps_req.rd) begin
        ps_rdata <= rdata_next;
      end
    end
  end

  // Registered write answer: accepted or refused
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ps_wack <= 1'b0;
      ps_werr <= 1'b0;
    end else begin
      ps_wack <= ps_req.wr && wr_ok;
      ps_werr <= ps_req.wr && !wr_ok;
    end
  end

endmodule

// file: verif/tile_status_security_regs_asserts.sv
// Port-level checks for the tile status register bank
`timescale 1ns/1ns
module tile_status_security_regs_asserts (
  // Clock and reset
  input wire logic                             ref_clk,
  input wire logic                             sys_rst,
  // Status port
  input wire tile_status_pkg::ps_req_s         ps_req,
  input wire logic [31:0]                      ps_rdata,
  input wire logic                             ps_rvalid,
  input wire logic                             ps_wack,
  input wire logic                             ps_werr,
  // Side inputs and decoded outputs
  input wire logic                             otp_load,
  input wire logic [31:0]                      otp_security_word,
  input wire logic                             debug_mode,
  input wire logic                             core_osc_en,
  input wire logic                             periph_osc_en,
  input wire tile_status_pkg::sec_ctrl_s       sec_ctrl
);
  import tile_status_pkg::*;
  logic [31:0] otp_d1;
  logic [31:0] otp_d2;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Word loaded two edges back, for the decode check
  always_ff @(posedge ref_clk) begin
    otp_d1 <= otp_security_word;
    otp_d2 <= otp_d1;
  end
  a_read_answer: assert property (ps_req.rd |=> ps_rvalid && !ps_wack)
    else $error("read not answered next cycle");
  a_write_answer: assert property (ps_req.wr |=> ps_wack != ps_werr)
    else $error("write not answered once next cycle");
  a_lock_refuse: assert property (ps_req.wr && ps_req.addr == 8'h05
    && sec_ctrl.write_locked && !otp_load && !$past(otp_load) |=> ps_werr)
    else $error("write to locked security register accepted");
  a_ro_refuse: assert property (ps_req.wr && ps_req.addr inside
    {8'h03, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0C} |=> ps_werr && !ps_wack)
    else $error("write to read-only register accepted");
  a_debug_guard: assert property (ps_req.wr && !debug_mode
    && ps_req.addr inside {8'h10, 8'h11} |=> ps_werr)
    else $error("debug register written outside debug mode");
  a_osc_follow: assert property (ps_req.wr && ps_req.addr == 8'h06
    |-> ##2 {core_osc_en, periph_osc_en} == $past(ps_req.wdata[1:0], 2))
    else $error("oscillator enables do not follow control write");
  a_count_width: assert property (ps_req.rd && ps_req.addr inside
    {[8'h07:8'h0A]} |=> ps_rdata[31:16] == 16'h0000)
    else $error("oscillator count upper bits not zero");
  a_ram_low: assert property (ps_req.rd && ps_req.addr == 8'h0C
    |=> ps_rdata[1:0] == 2'h0)
    else $error("ram size low bits not zero");
  a_otp_copy: assert property (otp_load |-> ##2 sec_ctrl ==
    {otp_d2[31], otp_d2[14], otp_d2[12], otp_d2[11:8], otp_d2[7], otp_d2[5:4], otp_d2[0]})
    else $error("security controls differ from loaded word");
endmodule

// file: verif/ring_osc_model.sv
// Behavioural ring oscillators, gated by the bank's enables
`timescale 1ns/1ns
module ring_osc_model (
  // Enables from the bank
  input wire logic         core_osc_en,
  input wire logic         periph_osc_en,
  // Oscillator outputs and rising edge tallies
  output logic [3:0]       osc_raw,
  output logic [63:0]      rise_cnt
);
  int ph [4];
  // Each ring has its own period, unrelated to the core clock; held still when stopped
  initial begin
    osc_raw = 4'h0;
    rise_cnt = '0;
    ph = '{0, 0, 0, 0};
    forever begin
      #1;
      for (int i = 0; i < 4; i++) begin
        if (i < 2 ? core_osc_en : periph_osc_en) ph[i]++;
        if (ph[i] == 13 + 4 * i) begin
          ph[i] = 0;
          osc_raw[i] = ~osc_raw[i];
          if (osc_raw[i]) rise_cnt[16*i +: 16] += 16'h0001;
        end
      end
    end
  end
endmodule

// file: verif/tb_tile_status_security_regs.sv
// Self-checking bench for the tile status register bank
`timescale 1ns/1ns
module tb_tile_status_security_regs;
  import tile_status_pkg::*;
  // One table case: optional write, then a read-back
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] data;
    logic        err;
    logic [7:0]  raddr;
    logic [31:0] exp;
  } row_s;
  localparam logic [31:0] BOOT_EXP = 32'h005A0116; // Straps below in their fields
  localparam logic [31:0] RAM_SZ   = 32'h00020003;
  logic                ref_clk, sys_rst, por_rst, otp_load, debug_mode, debug_enter;
  ps_req_s             ps_req;
  logic [31:0]         ps_rdata, otp_security_word, saved_program_counter, rd_val;
  logic                ps_rvalid, ps_wack, ps_werr, core_osc_en, periph_osc_en;
  logic [2:0]          rsp_val;
  boot_straps_s        boot_straps;
  logic [10:0]         saved_status_word;
  logic [3:0]          osc_raw;
  sec_ctrl_s           sec_ctrl;
  logic [63:0]         rise_cnt, cnt_snap;
  int                  miscompares, checks;
  int                  cycles = 0;
  row_s rows [12] = '{
    '{1'b0, 8'h00, 32'h0, 1'b0, 8'h03, BOOT_EXP},
    '{1'b0, 8'h00, 32'h0, 1'b0, 8'h0C, {RAM_SZ[31:2], 2'h0}},
    '{1'b0, 8'h00, 32'h0, 1'b0, 8'h05, 32'h00005FB1},
    '{1'b0, 8'h00, 32'h0, 1'b0, 8'h10, 32'h000007DF},
    '{1'b0, 8'h00, 32'h0, 1'b0, 8'h11, 32'hCAFE0123},
    '{1'b1, 8'h10, 32'h0, 1'b1, 8'h10, 32'h000007DF},
    '{1'b1, 8'h03, 32'hFFFFFFFF, 1'b1, 8'h03, BOOT_EXP},
    '{1'b1, 8'h0B, 32'hFFFFFFFF, 1'b1, 8'h05, 32'h00005FB1},
    '{1'b1, 8'h05, 32'hFFFFFFFF, 1'b0, 8'h05, 32'h80005FB1},
    '{1'b1, 8'h05, 32'h0, 1'b1, 8'h05, 32'h80005FB1},
    '{1'b1, 8'h06, 32'hFFFFFFFF, 1'b0, 8'h06, 32'h00000003},
    '{1'b1, 8'h06, 32'h0, 1'b0, 8'h06, 32'h0}
  };
  tile_status_security_regs #(.RAM_SIZE(RAM_SZ)) i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .por_rst(por_rst), .ps_req(ps_req), .ps_rdata(ps_rdata), .ps_rvalid(ps_rvalid),
    .ps_wack(ps_wack), .ps_werr(ps_werr), .boot_straps(boot_straps), .otp_load(otp_load),
    .otp_security_word(otp_security_word), .debug_mode(debug_mode),
    .debug_enter(debug_enter), .saved_status_word(saved_status_word),
    .saved_program_counter(saved_program_counter), .osc_raw(osc_raw),
    .core_osc_en(core_osc_en), .periph_osc_en(periph_osc_en), .sec_ctrl(sec_ctrl));
  ring_osc_model i_osc (.core_osc_en(core_osc_en), .periph_osc_en(periph_osc_en),
    .osc_raw(osc_raw), .rise_cnt(rise_cnt));
  // Core clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One status access; one-cycle answer pulses sampled just after the edge that takes it
  task automatic ps_op(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    ps_req <= '{rd: !wr, wr: wr, addr: a, wdata: d};
    @(posedge ref_clk);
    ps_req <= '0;
    #1;
    rd_val = ps_rdata;
    rsp_val = {ps_rvalid, ps_wack, ps_werr};
  endtask
  task automatic reset_pulse();
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    por_rst <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic check_counts();
    for (int i = 0; i < 4; i++) begin
      ps_op(1'b0, 8'h07 + 8'(i), 32'h0);
      check(rd_val, {16'h0000, cnt_snap[16*i +: 16]});
      check({29'h0, rsp_val}, 32'h4);
    end
  endtask
  task automatic test_done();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    ps_req = '0;
    sys_rst = 1'b1;
    por_rst = 1'b1;
    otp_load = 1'b0;
    otp_security_word = 32'h7FFFFFFF;
    debug_mode = 1'b0;
    debug_enter = 1'b0;
    saved_status_word = 11'h7FF;
    saved_program_counter = 32'hCAFE0123;
    boot_straps = '{8'h5A, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 2'h2};
    miscompares = 0;
    checks = 0;
    reset_pulse();
    ps_op(1'b0, 8'h06, 32'h0);
    check(rd_val, 32'h0);
    check({30'h0, core_osc_en, periph_osc_en}, 32'h0);
    @(posedge ref_clk);
    otp_load <= 1'b1;
    debug_enter <= 1'b1;
    @(posedge ref_clk);
    otp_load <= 1'b0;
    debug_enter <= 1'b0;
    @(posedge ref_clk);
    #1;
    check({21'h0, sec_ctrl}, 32'h000003FF);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        ps_op(1'b1, rows[i].addr, rows[i].data);
        check({29'h0, rsp_val}, {30'h0, !rows[i].err, rows[i].err});
      end
      ps_op(1'b0, rows[i].raddr, 32'h0);
      check({29'h0, rsp_val}, 32'h4);
      check(rd_val, rows[i].exp);
    end
    check({21'h0, sec_ctrl}, 32'h000007FF);
    // Debug writes only in debug mode; current issue mode bit kept
    @(posedge ref_clk);
    debug_mode <= 1'b1;
    ps_op(1'b1, 8'h10, 32'h0);
    check({29'h0, rsp_val}, 32'h2);
    ps_op(1'b0, 8'h10, 32'h0);
    check(rd_val, 32'h00000100);
    ps_op(1'b1, 8'h11, 32'h12345678);
    check({29'h0, rsp_val}, 32'h2);
    ps_op(1'b0, 8'h11, 32'h0);
    check(rd_val, 32'h12345678);
    // Run the rings, stop them, wait past the settle time, read counts
    ps_op(1'b1, 8'h06, 32'h00000003);
    repeat (300) @(posedge ref_clk);
    ps_op(1'b1, 8'h06, 32'h0);
    repeat (12) @(posedge ref_clk);
    cnt_snap = rise_cnt;
    check({31'h0, cnt_snap[15:0] != 16'h0}, 32'h1);
    check_counts();
    // Counts survive a system reset; control returns to zero
    reset_pulse();
    check_counts();
    ps_op(1'b0, 8'h06, 32'h0);
    check(rd_val, 32'h0);
    check({30'h0, core_osc_en, periph_osc_en}, 32'h0);
    test_done();
  end
endmodule
bind tile_status_security_regs tile_status_security_regs_asserts i_chk (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .ps_req(ps_req), .ps_rdata(ps_rdata), .ps_rvalid(ps_rvalid),
  .ps_wack(ps_wack), .ps_werr(ps_werr), .otp_load(otp_load),
  .otp_security_word(otp_security_word), .debug_mode(debug_mode),
  .core_osc_en(core_osc_en), .periph_osc_en(periph_osc_en), .sec_ctrl(sec_ctrl));
